// *** bench/tks_ctrl_test.sv ***
// self-checking bench of the touch key scan controller
`timescale 1ns/1ps
module tks_ctrl_test
  import tks_pkg::*;
;
  localparam int NM = TKS_NUM_MOD;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, b;
  logic [15:0] w;
  logic [NM*TKS_KEYS-1:0] key_sense, key_osc_run, key_pin_sel;
  logic [NM-1:0] ref_osc, ref_osc_run;
  logic touch_irq;
  int bad_count = 0;
  int checked = 0;
  int cyc_n = 0;
  int lfsr = 26438;
  int took, p0, t0, k;

  always #20 mclk = ~mclk;
  always @(posedge mclk) cyc_n <= cyc_n + 1;

  tks_ctrl #(.NUM_MOD(NM)) dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .key_sense(key_sense), .ref_osc(ref_osc), .key_osc_run(key_osc_run),
    .ref_osc_run(ref_osc_run), .key_pin_sel(key_pin_sel), .touch_irq(touch_irq));
  tks_pads #(.NUM_MOD(NM)) pads_u (.mclk(mclk), .key_osc_run(key_osc_run), .ref_osc_run(ref_osc_run),
    .key_sense(key_sense), .ref_osc(ref_osc));

  // ****
  // tasks
  // ****
  function automatic int next_rand(input int v);
    return (v >> 1) ^ ((v & 1) != 0 ? 32'h0000b400 : 32'h0);
  endfunction
  // model: a scan lasts (256 - preset) slots of 32 ticks, tick given in mclk cycles
  function automatic int slot_cycles(input int preset, input int tick);
    return (256 - preset) * 32 * tick;
  endfunction
  function automatic logic [7:0] ra(input int m, input logic [2:0] o);
    return {TKS_MOD_PAGE0 + 5'(m), o};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // window check: counts move with oscillator phase
  task automatic near(input logic [31:0] seen, input int exp, input int tol, input string what);
    check(32'(seen >= 32'(exp - tol) && seen <= 32'(exp + tol)), 32'd1, what);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  task automatic rd_cnt(input int m, input logic [2:0] o, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd_reg(ra(m, o), lo);
    rd_reg(ra(m, o + 3'h1), hi);
    v = {hi, lo};
  endtask
  // run_exp is {ref_osc_run, key_osc_run} expected while scanning
  task automatic run_scan(input logic share, input logic [NM*9-1:0] run_exp, input int limit, output int t);
    int s;
    wr_reg(TKS_GCTRL_ADDR, {6'h00, share, 1'b1});
    s = cyc_n;
    t = -1;
    repeat (3) @(negedge mclk);
    check({ref_osc_run, key_osc_run}, 32'(run_exp), "oscillator run");
    for (int i = 0; i < limit && t < 0; i++) begin
      @(negedge mclk);
      if (touch_irq === 1'b1) t = cyc_n - s;
    end
    if (t < 0) check(32'd0, 32'd1, "no scan end");
    repeat (2) @(negedge mclk);
    check({ref_osc_run, key_osc_run}, 32'd0, "oscillators after end");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****
  // watchdog, longest scan is about 67000 cycles
  // ****
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(TKS_GCTRL_ADDR, b);
    check(b, TKS_REG_RST, "global reset");
    for (int m = 0; m < NM; m++) begin
      for (int o = 0; o < 3; o++) begin
        rd_reg(ra(m, 3'(o)), b);
        check(b, TKS_REG_RST, "module reset");
      end
    end
    check(key_pin_sel, 32'd0, "pin reset");
    wr_reg(8'h08, 8'hff);
    rd_reg(8'h08, b);
    check(b, 8'h00, "unmapped");
    rd_reg(TKS_GCTRL_ADDR, b);
    check(b, TKS_REG_RST, "unmapped write ignored");
    wr_reg(ra(0, TKS_OFS_CTRL1), 8'hff);
    rd_reg(ra(0, TKS_OFS_CTRL1), b);
    check(b, 8'hff & TKS_C1_MASK, "ctrl one");
    @(negedge mclk);
    check(rdata, 8'h00, "read data stands one cycle");
    wr_reg(ra(0, TKS_OFS_CTRL2), 8'hff);
    rd_reg(ra(0, TKS_OFS_CTRL2), b);
    check(b, 8'hff & TKS_C2_MASK, "ctrl two");
    // module 0 on mclk over four without reference, module 1 on its reference
    wr_reg(ra(0, TKS_OFS_CTRL1), 8'h9f);
    wr_reg(ra(1, TKS_OFS_CTRL1), 8'h3a);
    wr_reg(ra(1, TKS_OFS_CTRL2), 8'h05);
    wr_reg(ra(1, TKS_OFS_SLOT), 8'hfc);
    wr_reg(ra(0, TKS_OFS_SLOT), 8'hfc);
    repeat (2) @(negedge mclk);
    check(key_pin_sel, 32'h5aff, "pin function");
    for (k = 0; k < 8; k++) begin
      wr_reg(ra(0, TKS_OFS_CTRL2), {3'(k), 5'h0f});
      run_scan(1'b1, 18'h25aff, 2000, took);
      near(took, slot_cycles(8'hfc, 4), 8, "slot period");
      rd_cnt(0, TKS_OFS_CYC_LO, w);
      near(w, 512 / (4 + 2 * k), 2, "cycle count");
      rd_cnt(0, TKS_OFS_FUN_LO, w);
      near(w, 512, 8, "function count");
      rd_reg(TKS_GCTRL_ADDR, b);
      check(b, 8'h07, "slot flag");
      wr_reg(TKS_GCTRL_ADDR, 8'h00);
    end
    lfsr = next_rand(lfsr);
    p0 = 8'hf9 + lfsr % 6;
    t0 = slot_cycles(p0, 4);
    wr_reg(ra(0, TKS_OFS_SLOT), 8'(p0));
    run_scan(1'b1, 18'h25aff, 3000, took);
    near(took, t0, 8, "shared slot counter");
    wr_reg(TKS_GCTRL_ADDR, 8'h00);
    run_scan(1'b0, 18'h25aff, 3000, took);
    near(took, slot_cycles(8'hfc, 12), 24, "last module ends scan");
    rd_cnt(1, TKS_OFS_CYC_LO, w);
    check(w, 16'h0000, "disabled key counts nothing");
    rd_cnt(1, TKS_OFS_FUN_LO, w);
    near(w, slot_cycles(8'hfc, 12), 24, "module one function count");
    wr_reg(TKS_GCTRL_ADDR, 8'h00);
    // abort in mid-scan, then a full scan must start from zero
    wr_reg(ra(0, TKS_OFS_SLOT), 8'hfc);
    wr_reg(TKS_GCTRL_ADDR, 8'h03);
    repeat (100) @(posedge mclk);
    wr_reg(TKS_GCTRL_ADDR, 8'h02);
    repeat (3) @(negedge mclk);
    check({ref_osc_run, key_osc_run}, 32'd0, "abort stops oscillators");
    for (int i = 0; i < 600; i++) begin
      @(negedge mclk);
      if (touch_irq !== 1'b0) check(touch_irq, 1'b0, "end after abort");
    end
    run_scan(1'b1, 18'h25aff, 2000, took);
    rd_cnt(0, TKS_OFS_FUN_LO, w);
    near(w, slot_cycles(8'hfc, 4), 8, "fresh function count");
    wr_reg(TKS_GCTRL_ADDR, 8'h00);
    // long slot on the reference so the function counter wraps
    wr_reg(ra(0, TKS_OFS_CTRL1), 8'h3f);
    wr_reg(ra(0, TKS_OFS_SLOT), 8'h30);
    run_scan(1'b1, 18'h35aff, 70000, took);
    rd_reg(TKS_GCTRL_ADDR, b);
    check(b, 8'h17, "function overflow");
    wr_reg(TKS_GCTRL_ADDR, 8'h10);
    rd_reg(TKS_GCTRL_ADDR, b);
    check(b, 8'h10, "flag kept");
    wr_reg(TKS_GCTRL_ADDR, 8'h00);
    rd_reg(TKS_GCTRL_ADDR, b);
    check(b, 8'h00, "flags cleared");
    complete_run();
  end
endmodule

// *** bench/tks_pads.sv ***
// pad model: sense and reference oscillators behind the touch pins
`timescale 1ns/1ps
module tks_pads
  import tks_pkg::*;
#(
  parameter int NUM_MOD = TKS_NUM_MOD
) (
  // clock
  input wire logic mclk,
  // run enables
  input wire logic [NUM_MOD*TKS_KEYS-1:0] key_osc_run,
  input wire logic [NUM_MOD-1:0] ref_osc_run,
  // oscillator levels
  output logic [NUM_MOD*TKS_KEYS-1:0] key_sense,
  output logic [NUM_MOD-1:0] ref_osc
);
  int kc [NUM_MOD*TKS_KEYS] = '{default: 0};
  int rc [NUM_MOD] = '{default: 0};
  initial begin
    key_sense = '0;
    ref_osc = '0;
  end
  // rates differ per key so a wrong key choice shows in the count
  always @(posedge mclk) begin
    for (int i = 0; i < NUM_MOD*TKS_KEYS; i++) begin
      kc[i] = key_osc_run[i] ? kc[i] + 1 : 0;
      if (!key_osc_run[i]) key_sense[i] <= 1'b0;
      else if (kc[i] >= 2 + i % 8 + i / 8) begin
        kc[i] = 0;
        key_sense[i] <= ~key_sense[i];
      end
    end
    for (int m = 0; m < NUM_MOD; m++) begin
      rc[m] = ref_osc_run[m] ? rc[m] + 1 : 0;
      if (!ref_osc_run[m]) ref_osc[m] <= 1'b0;
      else if (rc[m] >= 5 + m) begin
        rc[m] = 0;
        ref_osc[m] <= ~ref_osc[m];
      end
    end
  end
endmodule

// *** hw/tks_ctrl.sv ***
// top: registers, scan sequencer and oscillator control of the touch keys
//
// Overview of operation
// - each module has eight keys on shared pins, each with its own oscillator
// - count sense oscillator cycles during the slot; interrupt when it ends
// - share select makes module 0 slot counter serve every module
// - one common start bit launches every module
// - start bit low clears cycle, function and unit counters, not slot counter
// - slot overflow period is set by software through the slot setting
// - start bit rising switches on all four counters in every module
// - slot overflow stops key and reference oscillators and all counters
// - slot clock is the reference oscillator or system clock divided by four
// - reference and key oscillators run only while their enables are set
// - interrupt on overflow of all modules or module 0; only enabled keys count
// - module 0 holds keys one to eight, module 1 nine to sixteen, identical
// - single interrupt source; it clears all four counters of every module
// - start rising enables and syncs oscillators; set it after configuration
// - slot overflow sets a sticky flag and the interrupt; software clears it
// - any module cycle counter overflow sets a sticky flag; software clears it
// - function counter overflow sets a sticky flag; software clears it
// - slot clock select: 0 reference oscillator, 1 system clock over four
// - key enable 0 gives the pin to I/O, 1 to the touch key; reset 0
// - three-bit key select, 000 first key through 111 eighth key
`timescale 1ns/1ps
module tks_ctrl
  import tks_pkg::*;
#(
  parameter int NUM_MOD = TKS_NUM_MOD
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // oscillators, module n owns keys 8n to 8n+7
  input wire logic [NUM_MOD*TKS_KEYS-1:0] key_sense,
  input wire logic [NUM_MOD-1:0] ref_osc,
  output logic [NUM_MOD*TKS_KEYS-1:0] key_osc_run,
  output logic [NUM_MOD-1:0] ref_osc_run,
  // pin function and interrupt
  output logic [NUM_MOD*TKS_KEYS-1:0] key_pin_sel,
  output logic touch_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tks_state_t state;
    logic start;
    logic start_pulse;
    logic share;
    logic slot_flag;
    logic cyc_flag;
    logic fun_flag;
    logic [NUM_MOD-1:0][7:0] ctrl1;
    logic [NUM_MOD-1:0][7:0] ctrl2;
    logic [NUM_MOD-1:0][7:0] slot_set;
    logic [NUM_MOD-1:0][15:0] cap_cyc;
    logic [NUM_MOD-1:0][15:0] cap_fun;
    logic [NUM_MOD-1:0] done;
    logic [7:0] rdata;
    logic irq;
    logic [NUM_MOD*TKS_KEYS-1:0] pin_sel;
    logic [NUM_MOD*TKS_KEYS-1:0] key_run;
    logic [NUM_MOD-1:0] ref_run;
  } tks_st_t;

  tks_st_t st;
  tks_st_t next_st;
  logic [NUM_MOD-1:0][15:0] cyc_w;
  logic [NUM_MOD-1:0][15:0] fun_w;
  logic [NUM_MOD-1:0] slot_ovf_w;
  logic [NUM_MOD-1:0] cyc_ovf_w;
  logic [NUM_MOD-1:0] fun_ovf_w;
  logic [NUM_MOD-1:0] run_w;
  logic scanning;
  logic share_end;
  logic all_end;
  logic irq_evt;
  logic gc_wr;
  logic [4:0] page;
  logic [4:0] mod_idx;
  logic mod_hit;
  logic [7:0] gc_read;

  // ****************************************
  // per-module counters
  // ****************************************
  genvar gm;
  generate
    for (gm = 0; gm < NUM_MOD; gm++) begin : g_mod
      assign run_w[gm] = scanning & ~st.done[gm];
      tks_module u_mod (
        .mclk(mclk),
        .rst(rst),
        .run(run_w[gm]),
        .start_pulse(st.start_pulse),
        .clr_cnt(~st.start),
        .clr_all(st.irq),
        .slot_preset(st.slot_set[gm]),
        .tss(st.ctrl1[gm][TKS_C1_TSS]),
        .mxs(st.ctrl2[gm][7:TKS_C2_MXS_LSB]),
        .key_en({st.ctrl2[gm][3:0], st.ctrl1[gm][3:0]}),
        .key_sense(key_sense[gm*TKS_KEYS +: TKS_KEYS]),
        .ref_osc(ref_osc[gm]),
        .cyc_cnt(cyc_w[gm]),
        .fun_cnt(fun_w[gm]),
        .slot_ovf(slot_ovf_w[gm]),
        .cyc_ovf(cyc_ovf_w[gm]),
        .fun_ovf(fun_ovf_w[gm])
      );
    end
  endgenerate

  // ****************************************
  // decode and scan sequencer
  // ****************************************
  assign scanning = (st.state == TKS_SCAN) & ~st.start_pulse;
  assign share_end = st.share & slot_ovf_w[0];
  assign all_end = &(st.done | slot_ovf_w);
  assign irq_evt = scanning & (st.share ? share_end : all_end);
  assign gc_wr = wr & (addr == TKS_GCTRL_ADDR);
  assign page = addr[7:3];
  assign mod_idx = page - TKS_MOD_PAGE0;
  assign mod_hit = (page >= TKS_MOD_PAGE0) & (mod_idx < 5'(NUM_MOD));

  always_comb begin
    gc_read = TKS_REG_RST;
    gc_read[TKS_GC_START] = st.start;
    gc_read[TKS_GC_SHARE] = st.share;
    gc_read[TKS_GC_SLOT_OV] = st.slot_flag;
    gc_read[TKS_GC_CYC_OV] = st.cyc_flag;
    gc_read[TKS_GC_FUN_OV] = st.fun_flag;
    next_st = st;
    next_st.start_pulse = 1'b0;
    next_st.irq = irq_evt;
    next_st.rdata = TKS_REG_RST;
    // register writes
    if (gc_wr) begin
      next_st.start = wdata[TKS_GC_START];
      next_st.share = wdata[TKS_GC_SHARE];
      // flags clear on a written zero, the set terms below win
      next_st.slot_flag = st.slot_flag & wdata[TKS_GC_SLOT_OV];
      next_st.cyc_flag = st.cyc_flag & wdata[TKS_GC_CYC_OV];
      next_st.fun_flag = st.fun_flag & wdata[TKS_GC_FUN_OV];
    end
    if (wr & mod_hit) begin
      case (addr[2:0])
        TKS_OFS_CTRL1: next_st.ctrl1[mod_idx] = wdata & TKS_C1_MASK;
        TKS_OFS_CTRL2: next_st.ctrl2[mod_idx] = wdata & TKS_C2_MASK;
        TKS_OFS_SLOT: next_st.slot_set[mod_idx] = wdata;
        default: next_st.slot_set = st.slot_set;
      endcase
    end
    // register reads
    if (rd & (addr == TKS_GCTRL_ADDR)) begin
      next_st.rdata = gc_read;
    end else if (rd & mod_hit) begin
      case (addr[2:0])
        TKS_OFS_CTRL1: next_st.rdata = st.ctrl1[mod_idx];
        TKS_OFS_CTRL2: next_st.rdata = st.ctrl2[mod_idx];
        TKS_OFS_SLOT: next_st.rdata = st.slot_set[mod_idx];
        TKS_OFS_CYC_LO: next_st.rdata = st.cap_cyc[mod_idx][7:0];
        TKS_OFS_CYC_HI: next_st.rdata = st.cap_cyc[mod_idx][15:8];
        TKS_OFS_FUN_LO: next_st.rdata = st.cap_fun[mod_idx][7:0];
        TKS_OFS_FUN_HI: next_st.rdata = st.cap_fun[mod_idx][15:8];
        default: next_st.rdata = TKS_REG_RST;
      endcase
    end
    // sticky overflow flags
    if (scanning & |cyc_ovf_w) begin
      next_st.cyc_flag = 1'b1;
    end
    if (scanning & |fun_ovf_w) begin
      next_st.fun_flag = 1'b1;
    end
    if (irq_evt) begin
      next_st.slot_flag = 1'b1;
    end
    // sequencer
    case (st.state)
      TKS_IDLE: begin
        if (next_st.start) begin
          // configuration must already be in place at this edge
          next_st.state = TKS_SCAN;
          next_st.start_pulse = 1'b1;
          next_st.done = '0;
        end
      end
      TKS_SCAN: begin
        if (~next_st.start) begin
          next_st.state = TKS_IDLE;
        end else if (irq_evt) begin
          // results are held here, the counters are cleared a cycle later
          next_st.state = TKS_DONE;
          next_st.cap_cyc = cyc_w;
          next_st.cap_fun = fun_w;
        end else begin
          next_st.done = st.done | (st.share ? {NUM_MOD{share_end}} : slot_ovf_w);
        end
      end
      TKS_DONE: begin
        // a new scan needs the start bit to go low first
        if (~next_st.start) begin
          next_st.state = TKS_IDLE;
        end
      end
      default: next_st.state = TKS_IDLE;
    endcase
    // oscillator enables follow the next state
    for (int m = 0; m < NUM_MOD; m++) begin
      next_st.pin_sel[m*TKS_KEYS +: TKS_KEYS] = {next_st.ctrl2[m][3:0], next_st.ctrl1[m][3:0]};
      next_st.ref_run[m] = (next_st.state == TKS_SCAN) & ~next_st.done[m] & next_st.ctrl1[m][TKS_C1_ROEN];
      for (int k = 0; k < TKS_KEYS; k++) begin
        next_st.key_run[m*TKS_KEYS+k] = (next_st.state == TKS_SCAN) & ~next_st.done[m]
          & next_st.ctrl1[m][TKS_C1_KOEN] & next_st.pin_sel[m*TKS_KEYS+k];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= TKS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign key_osc_run = st.key_run;
  assign ref_osc_run = st.ref_run;
  assign key_pin_sel = st.pin_sel;
  assign touch_irq = st.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_scan_end;
    irq_evt ##1 touch_irq;
  endsequence
  sequence s_scan_begin;
    (st.state == TKS_IDLE) ##1 st.start_pulse;
  endsequence
  sequence s_div_gap;
    (!g_mod[0].u_mod.slot_tick || !st.ctrl1[0][TKS_C1_TSS]) [*3];
  endsequence

  property p_irq_pulse;
    irq_evt |=> touch_irq ##1 !touch_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not one cycle");

  property p_slot_flag;
    s_scan_end |-> st.slot_flag;
  endproperty
  a_slot_flag: assert property (p_slot_flag) else $error("slot flag not set");

  property p_slot_sticky;
    (st.slot_flag && !gc_wr) |=> st.slot_flag;
  endproperty
  a_slot_sticky: assert property (p_slot_sticky) else $error("slot flag lost");

  property p_osc_stop;
    irq_evt |=> (key_osc_run == '0) && (ref_osc_run == '0);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillators still run");

  property p_start_clr;
    $fell(st.start) |=> (cyc_w[0] == '0) && (fun_w[0] == '0);
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("counters not cleared");

  property p_start_scan;
    (st.state == TKS_IDLE && !st.start && gc_wr && wdata[TKS_GC_START]) |-> s_scan_begin
      ##1 (st.state == TKS_SCAN);
  endproperty
  a_start_scan: assert property (p_start_scan) else $error("scan not started");

  property p_share_end;
    (scanning && st.share && slot_ovf_w[0] && st.start) |=> (st.state == TKS_DONE);
  endproperty
  a_share_end: assert property (p_share_end) else $error("shared slot end missed");

  property p_cyc_flag;
    (scanning && |cyc_ovf_w) |=> st.cyc_flag;
  endproperty
  a_cyc_flag: assert property (p_cyc_flag) else $error("cycle overflow flag not set");

  property p_fun_flag;
    (scanning && |fun_ovf_w) |=> st.fun_flag;
  endproperty
  a_fun_flag: assert property (p_fun_flag) else $error("function overflow flag not set");

  property p_osc_gate;
    (ref_osc_run[0]) |-> (st.state == TKS_SCAN) && st.ctrl1[0][TKS_C1_ROEN];
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("reference oscillator runs disabled");

  property p_pin_sel;
    (wr && addr == {TKS_MOD_PAGE0, TKS_OFS_CTRL1}) |=> ##1 (key_pin_sel[3:0] == $past(wdata[3:0], 2));
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin function not applied");

  // the end clears every module, one cycle after the pulse
  property p_clr_all;
    touch_irq |=> (cyc_w == '0) && (fun_w == '0);
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("counters not cleared at end");

  // an aborted scan keeps its slot count until the next start
  property p_slot_keep;
    (st.state == TKS_IDLE && !st.irq) |=> $stable(g_mod[0].u_mod.st.slot);
  endproperty
  a_slot_keep: assert property (p_slot_keep) else $error("slot counter changed while idle");

  property p_flag_clear;
    (gc_wr && !wdata[TKS_GC_SLOT_OV] && !irq_evt) |=> !st.slot_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("slot flag not cleared");

  property p_all_end;
    (scanning && !st.share && !all_end) |=> !touch_irq;
  endproperty
  a_all_end: assert property (p_all_end) else $error("interrupt before all modules ended");

  property p_key_gate;
    key_osc_run[0] |-> st.ctrl1[0][TKS_C1_KOEN] && key_pin_sel[0] && (st.state == TKS_SCAN);
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("key oscillator runs disabled");

  property p_tss_tick;
    (run_w[0] && st.ctrl1[0][TKS_C1_TSS] && g_mod[0].u_mod.slot_tick) |=> s_div_gap;
  endproperty
  a_tss_tick: assert property (p_tss_tick) else $error("slot clock not mclk over four");
endmodule

// *** hw/tks_module.sv ***
// one touch module: key select, unit period, time slot and result counters
`timescale 1ns/1ps
module tks_module
  import tks_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencing
  input wire logic run,
  input wire logic start_pulse,
  input wire logic clr_cnt,
  input wire logic clr_all,
  // configuration
  input wire logic [7:0] slot_preset,
  input wire logic tss,
  input wire logic [2:0] mxs,
  input wire logic [7:0] key_en,
  // oscillators
  input wire logic [7:0] key_sense,
  input wire logic ref_osc,
  // results
  output logic [15:0] cyc_cnt,
  output logic [15:0] fun_cnt,
  output logic slot_ovf,
  output logic cyc_ovf,
  output logic fun_ovf
);
  typedef struct packed {
    logic [7:0] key_prev;
    logic ref_prev;
    logic [1:0] div;
    logic [4:0] unit;
    logic [7:0] slot;
    logic [15:0] cyc;
    logic [15:0] fun;
  } tks_mod_st_t;

  tks_mod_st_t st;
  tks_mod_st_t next_st;
  logic slot_tick;
  logic key_edge;
  logic unit_wrap;

  always_comb begin
    // the selected key only counts while its pin is given to the touch function
    key_edge = key_sense[mxs] & ~st.key_prev[mxs] & key_en[mxs];
    slot_tick = tss ? (st.div == TKS_DIV_LAST) : (ref_osc & ~st.ref_prev);
    unit_wrap = slot_tick & (st.unit == TKS_UNIT_LAST);
    slot_ovf = run & unit_wrap & (st.slot == TKS_SLOT_LAST);
    cyc_ovf = run & key_edge & (st.cyc == TKS_CNT_LAST);
    fun_ovf = run & (st.fun == TKS_CNT_LAST);
    cyc_cnt = st.cyc;
    fun_cnt = st.fun;
    next_st = st;
    next_st.key_prev = key_sense;
    next_st.ref_prev = ref_osc;
    if (start_pulse) begin
      next_st.slot = slot_preset;
      next_st.unit = '0;
      next_st.cyc = '0;
      next_st.fun = '0;
      next_st.div = '0;
    end else if (clr_all) begin
      next_st.slot = '0;
      next_st.unit = '0;
      next_st.cyc = '0;
      next_st.fun = '0;
    end else if (clr_cnt) begin
      // the slot counter keeps its value here
      next_st.unit = '0;
      next_st.cyc = '0;
      next_st.fun = '0;
    end else if (run) begin
      next_st.div = st.div + 2'h1;
      next_st.fun = st.fun + 16'h1;
      if (key_edge) begin
        next_st.cyc = st.cyc + 16'h1;
      end
      if (slot_tick) begin
        next_st.unit = st.unit + 5'h1;
      end
      if (unit_wrap) begin
        next_st.slot = st.slot + 8'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** hw/tks_pkg.sv ***
// package: constants, register map and types of the touch key scan controller
package tks_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int TKS_NUM_MOD = 2;
  localparam int TKS_KEYS = 8;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] TKS_GCTRL_ADDR = 8'h00;
  localparam logic [4:0] TKS_MOD_PAGE0 = 5'h02;
  localparam logic [2:0] TKS_OFS_CTRL1 = 3'h0;
  localparam logic [2:0] TKS_OFS_CTRL2 = 3'h1;
  localparam logic [2:0] TKS_OFS_SLOT = 3'h2;
  localparam logic [2:0] TKS_OFS_CYC_LO = 3'h3;
  localparam logic [2:0] TKS_OFS_CYC_HI = 3'h4;
  localparam logic [2:0] TKS_OFS_FUN_LO = 3'h5;
  localparam logic [2:0] TKS_OFS_FUN_HI = 3'h6;
  // ****************************************
  // field positions
  // ****************************************
  localparam int TKS_GC_START = 0;
  localparam int TKS_GC_SHARE = 1;
  localparam int TKS_GC_SLOT_OV = 2;
  localparam int TKS_GC_CYC_OV = 3;
  localparam int TKS_GC_FUN_OV = 4;
  localparam int TKS_C1_TSS = 7;
  localparam int TKS_C1_ROEN = 5;
  localparam int TKS_C1_KOEN = 4;
  localparam int TKS_C2_MXS_LSB = 5;
  localparam logic [7:0] TKS_C1_MASK = 8'hbf;
  localparam logic [7:0] TKS_C2_MASK = 8'hef;
  // ****************************************
  // reset values and counter limits
  // ****************************************
  localparam logic [7:0] TKS_REG_RST = 8'h00;
  localparam logic [1:0] TKS_DIV_LAST = 2'h3;
  localparam logic [4:0] TKS_UNIT_LAST = 5'h1f;
  localparam logic [7:0] TKS_SLOT_LAST = 8'hff;
  localparam logic [15:0] TKS_CNT_LAST = 16'hffff;
  // ****************************************
  // scan sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    TKS_IDLE = 3'b001,
    TKS_SCAN = 3'b010,
    TKS_DONE = 3'b100
  } tks_state_t;
endpackage
